// file: ctm_pkg.sv
// Compact timer package: register map, fields, modes, constants.
// Assumes an AXI4-Lite slave with 32-bit data, one register per aligned word.
package ctm_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [4:0] CTM_OFS_CONTROL_A = 5'h00;
    localparam logic [4:0] CTM_OFS_CONTROL_B = 5'h04;
    localparam logic [4:0] CTM_OFS_COUNT_LOW = 5'h08;
    localparam logic [4:0] CTM_OFS_COUNT_HIGH = 5'h0C;
    localparam logic [4:0] CTM_OFS_COMPARE_LOW = 5'h10;
    localparam logic [4:0] CTM_OFS_COMPARE_HIGH = 5'h14;
    localparam logic [4:0] CTM_OFS_FLAGS = 5'h18;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTM_BIT_PAUSE = 7;
    localparam int CTM_BIT_RUN = 3;
    localparam int CTM_BIT_INIT_LEVEL = 3;
    localparam int CTM_BIT_INVERT = 2;
    localparam int CTM_BIT_SWAP = 1;
    localparam int CTM_BIT_CLR_SEL = 0;
    localparam int CTM_BIT_FLAG_A = 0;
    localparam int CTM_BIT_FLAG_P = 1;

    localparam logic [7:0] CTM_RESET_BYTE = 8'h00;
    localparam logic [9:0] CTM_COUNT_MAX = 10'h3FF;
    localparam logic [1:0] CTM_AXI_OKAY = 2'h0;
    localparam logic [1:0] CTM_AXI_DECERR = 2'h3;

    // Prescaler ratios
    localparam int CTM_DIV_SYS = 4;
    localparam int CTM_DIV_H16 = 16;
    localparam int CTM_DIV_H64 = 64;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        CTM_MODE_COMPARE = 2'h0,
        CTM_MODE_UNDEF = 2'h1,
        CTM_MODE_PWM = 2'h2,
        CTM_MODE_TIMER = 2'h3
    } ctm_mode_e;

    typedef enum logic [2:0] {
        CTM_CLK_SYS4 = 3'h0,
        CTM_CLK_H = 3'h1,
        CTM_CLK_H16 = 3'h2,
        CTM_CLK_H64 = 3'h3,
        CTM_CLK_TB0 = 3'h4,
        CTM_CLK_TB1 = 3'h5,
        CTM_CLK_EXT_RISE = 3'h6,
        CTM_CLK_EXT_FALL = 3'h7
    } ctm_clk_e;

    typedef struct packed {
        logic pause_hold;
        logic [2:0] count_clock_select;
        logic counter_run_enable;
        logic [2:0] top_compare_value;
    } ctm_control_a_s;

    typedef struct packed {
        logic [1:0] operating_mode_select;
        logic [1:0] output_function_select;
        logic output_initial_level;
        logic output_invert;
        logic period_duty_swap;
        logic counter_clear_select;
    } ctm_control_b_s;

endpackage : ctm_pkg

// file: ctm_timer.sv
// Compact 10-bit timer with compare-match, timer/counter and PWM modes.
// Assumes an AXI4-Lite master on aclk; external pins are asynchronous to aclk.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps

module ctm_timer (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Internal clock enables
    input wire logic high_clock_tick,
    input wire logic timebase_clock_tick,
    // Pins
    input wire logic external_count_input,
    output logic timer_output_pin,
    output logic timer_output_pin_oe,
    // AXI4-Lite write address
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Compare events
    output logic compare_a_flag,
    output logic compare_p_flag
);

    // ************************************************************
    // Registers and bus
    // ************************************************************
    ctm_pkg::ctm_control_a_s ctl_a;
    ctm_pkg::ctm_control_b_s ctl_b;
    logic [9:0] count;
    logic [9:0] full_compare_value;
    logic [4:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic w_strb0;
    logic w_held;
    logic do_write;
    logic clear_a;
    logic clear_p;
    logic run_d;
    logic run_rise;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 5'h00;
            w_data <= 32'h0000_0000;
            w_strb0 <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb0 <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ctm_pkg::CTM_AXI_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr[4:2] <= ctm_pkg::CTM_OFS_FLAGS[4:2]) begin
                s_axi_bresp <= ctm_pkg::CTM_AXI_OKAY;
            end else begin
                s_axi_bresp <= ctm_pkg::CTM_AXI_DECERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Count registers are read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_a <= ctm_pkg::CTM_RESET_BYTE;
            ctl_b <= ctm_pkg::CTM_RESET_BYTE;
            full_compare_value <= 10'h000;
        end else if (do_write && w_strb0) begin
            if (aw_addr == ctm_pkg::CTM_OFS_CONTROL_A) begin
                ctl_a <= w_data[7:0];
            end else if (aw_addr == ctm_pkg::CTM_OFS_CONTROL_B) begin
                ctl_b <= w_data[7:0];
            end else if (aw_addr == ctm_pkg::CTM_OFS_COMPARE_LOW) begin
                full_compare_value[7:0] <= w_data[7:0];
            end else if (aw_addr == ctm_pkg::CTM_OFS_COMPARE_HIGH) begin
                full_compare_value[9:8] <= w_data[1:0];
            end
        end
    end

    assign clear_a = do_write && w_strb0 && aw_addr == ctm_pkg::CTM_OFS_FLAGS && w_data[ctm_pkg::CTM_BIT_FLAG_A];
    assign clear_p = do_write && w_strb0 && aw_addr == ctm_pkg::CTM_OFS_FLAGS && w_data[ctm_pkg::CTM_BIT_FLAG_P];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ctm_pkg::CTM_AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= ctm_pkg::CTM_AXI_OKAY;
            if (s_axi_araddr == ctm_pkg::CTM_OFS_CONTROL_A) begin
                s_axi_rdata <= {24'h000000, ctl_a};
            end else if (s_axi_araddr == ctm_pkg::CTM_OFS_CONTROL_B) begin
                s_axi_rdata <= {24'h000000, ctl_b};
            end else if (s_axi_araddr == ctm_pkg::CTM_OFS_COUNT_LOW) begin
                s_axi_rdata <= {24'h000000, count[7:0]};
            end else if (s_axi_araddr == ctm_pkg::CTM_OFS_COUNT_HIGH) begin
                s_axi_rdata <= {30'h0, count[9:8]};
            end else if (s_axi_araddr == ctm_pkg::CTM_OFS_COMPARE_LOW) begin
                s_axi_rdata <= {24'h000000, full_compare_value[7:0]};
            end else if (s_axi_araddr == ctm_pkg::CTM_OFS_COMPARE_HIGH) begin
                s_axi_rdata <= {30'h0, full_compare_value[9:8]};
            end else if (s_axi_araddr == ctm_pkg::CTM_OFS_FLAGS) begin
                s_axi_rdata <= {30'h0, compare_p_flag, compare_a_flag};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= ctm_pkg::CTM_AXI_DECERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Count clock selection
    // ************************************************************
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic [1:0] sys_div;
    logic [5:0] h_div;
    logic count_tick;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= external_count_input;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_div <= 2'h0;
            h_div <= 6'h00;
        end else begin
            sys_div <= sys_div + 2'h1;
            if (high_clock_tick) begin
                h_div <= h_div + 6'h01;
            end
        end
    end

    always_comb begin
        case (ctm_pkg::ctm_clk_e'(ctl_a.count_clock_select))
            ctm_pkg::CTM_CLK_SYS4: count_tick = sys_div == 2'(ctm_pkg::CTM_DIV_SYS - 1);
            ctm_pkg::CTM_CLK_H: count_tick = high_clock_tick;
            ctm_pkg::CTM_CLK_H16: count_tick = high_clock_tick && h_div[3:0] == 4'(ctm_pkg::CTM_DIV_H16 - 1);
            ctm_pkg::CTM_CLK_H64: count_tick = high_clock_tick && h_div == 6'(ctm_pkg::CTM_DIV_H64 - 1);
            ctm_pkg::CTM_CLK_TB0, ctm_pkg::CTM_CLK_TB1: count_tick = timebase_clock_tick;
            ctm_pkg::CTM_CLK_EXT_RISE: count_tick = ext_sync && !ext_prev;
            default: count_tick = !ext_sync && ext_prev;
        endcase
    end

    // ************************************************************
    // Counter, comparators and clear
    // ************************************************************
    logic running;
    logic match_a;
    logic match_p;
    logic overflow;
    logic is_pwm;
    logic clear_on_a;
    logic clear_now;
    logic [10:0] period_len;
    logic [10:0] duty_len;

    assign is_pwm = ctl_b.operating_mode_select == ctm_pkg::CTM_MODE_PWM;
    assign running = ctl_a.counter_run_enable && !ctl_a.pause_hold && count_tick;
    assign match_a = running && count == full_compare_value;
    assign match_p = running && ctl_a.top_compare_value != 3'h0 && count[6:0] == 7'h7F
        && count[9:7] == ctl_a.top_compare_value - 3'h1;
    assign overflow = running && count == ctm_pkg::CTM_COUNT_MAX;
    // PWM: period source clears the count
    assign clear_on_a = is_pwm ? ctl_b.period_duty_swap : ctl_b.counter_clear_select;

    // A match clears on the same tick
    always_comb begin
        if (clear_on_a) begin
            clear_now = match_a || overflow;
        end else begin
            clear_now = match_p || overflow;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_d <= 1'b0;
        end else begin
            run_d <= ctl_a.counter_run_enable;
        end
    end
    assign run_rise = ctl_a.counter_run_enable && !run_d;

    // Run rise wins over tick clears
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 10'h000;
        end else if (run_rise) begin
            count <= 10'h000;
        end else if (running) begin
            if (clear_now) begin
                count <= 10'h000;
            end else begin
                count <= count + 10'h001;
            end
        end
    end

    // Set wins over software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_a_flag <= 1'b0;
            compare_p_flag <= 1'b0;
        end else begin
            if (match_a && (full_compare_value != 10'h000 || count == 10'h000)) begin
                compare_a_flag <= 1'b1;
            end else if (clear_a) begin
                compare_a_flag <= 1'b0;
            end
            if (match_p && (is_pwm || !ctl_b.counter_clear_select)) begin
                compare_p_flag <= 1'b1;
            end else if (clear_p) begin
                compare_p_flag <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Output pin
    // ************************************************************
    logic cmp_level;
    logic pwm_level;
    logic pin_level;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_level <= 1'b0;
        end else if (run_rise) begin
            cmp_level <= ctl_b.output_initial_level;
        end else if (match_a && ctl_b.operating_mode_select == ctm_pkg::CTM_MODE_COMPARE) begin
            case (ctl_b.output_function_select)
                2'h1: cmp_level <= 1'b0;
                2'h2: cmp_level <= 1'b1;
                2'h3: cmp_level <= !cmp_level;
                default: cmp_level <= cmp_level;
            endcase
        end
    end

    assign period_len = ctl_b.period_duty_swap ? {1'b0, full_compare_value}
        : {(ctl_a.top_compare_value == 3'h0), ctl_a.top_compare_value, 7'h00};
    assign duty_len = ctl_b.period_duty_swap
        ? {(ctl_a.top_compare_value == 3'h0), ctl_a.top_compare_value, 7'h00}
        : {1'b0, full_compare_value};

    always_comb begin
        if (duty_len >= period_len) begin
            pwm_level = 1'b1;
        end else begin
            pwm_level = {1'b0, count} < duty_len;
        end
    end

    always_comb begin
        case (ctl_b.output_function_select)
            2'h0: pin_level = !ctl_b.output_initial_level;
            2'h1: pin_level = ctl_b.output_initial_level;
            2'h2: pin_level = pwm_level ? ctl_b.output_initial_level : !ctl_b.output_initial_level;
            default: pin_level = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_output_pin <= 1'b0;
            timer_output_pin_oe <= 1'b0;
        end else begin
            case (ctm_pkg::ctm_mode_e'(ctl_b.operating_mode_select))
                ctm_pkg::CTM_MODE_COMPARE: begin
                    timer_output_pin <= cmp_level ^ ctl_b.output_invert;
                    timer_output_pin_oe <= 1'b1;
                end
                ctm_pkg::CTM_MODE_PWM: begin
                    timer_output_pin <= pin_level ^ ctl_b.output_invert;
                    timer_output_pin_oe <= 1'b1;
                end
                default: begin
                    timer_output_pin <= 1'b0;
                    timer_output_pin_oe <= 1'b0;
                end
            endcase
        end
    end

endmodule : ctm_timer

// file: ctm_timer_props.sv
// Checker for the compact timer: bus, pin enable and flags.
// Assumes it is bound to ctm_timer and sees only its ports.
`timescale 1ns/100ps
module ctm_timer_props (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins and flags
    input wire logic timer_output_pin,
    input wire logic timer_output_pin_oe,
    input wire logic compare_a_flag,
    input wire logic compare_p_flag,
    // Write channels
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    ctm_pkg::ctm_control_b_s ctl_b;

    // ************************************************************
    // Shadow of the mode register
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_b <= '0;
        end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]
                     && s_axi_awaddr == ctm_pkg::CTM_OFS_CONTROL_B) begin
            ctl_b <= s_axi_wdata[7:0];
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_timer_no_pin;
        (ctl_b.operating_mode_select == 2'h3) [*3] |-> !timer_output_pin_oe;
    endproperty
    a_timer_no_pin: assert property (p_timer_no_pin) else $error("pin driven in timer mode");
    property p_pwm_force;
        (ctl_b.operating_mode_select == 2'h2 && ctl_b.output_function_select == 2'h1) [*3]
            |-> timer_output_pin == (ctl_b.output_initial_level ^ ctl_b.output_invert);
    endproperty
    a_pwm_force: assert property (p_pwm_force) else $error("forced active level wrong");
    property p_p_never;
        $rose(compare_p_flag) |-> !$past(ctl_b.counter_clear_select) || $past(ctl_b.operating_mode_select) == 2'h2;
    endproperty
    a_p_never: assert property (p_p_never) else $error("period flag raised with clear on A");
    property p_bvalid_after;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_bvalid_after: assert property (p_bvalid_after) else $error("write response late");
    property p_bvalid_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
    property p_rvalid_next;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rvalid_next: assert property (p_rvalid_next) else $error("read data late");
    property p_rvalid_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");
    property p_decerr;
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 5'h18
            |=> s_axi_rresp == ctm_pkg::CTM_AXI_DECERR && s_axi_rdata == 32'h0;
    endproperty
    a_decerr: assert property (p_decerr) else $error("unmapped read not refused");
endmodule : ctm_timer_props

bind ctm_timer ctm_timer_props u_ctm_timer_props (
    .aclk, .aresetn, .timer_output_pin, .timer_output_pin_oe, .compare_a_flag, .compare_p_flag,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

// file: ctm_pin_model.sv
// Partner model: drives the external count pin of the timer.
// Assumes the timer synchronises the pin to aclk.
`timescale 1ns/100ps
module ctm_pin_model (
    // Clock
    input wire logic aclk,
    // Pin toward the timer
    output logic count_out
);
    initial begin
        count_out = 1'b0;
    end

    // Levels held long enough to pass the synchroniser
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge aclk);
            count_out <= 1'b1;
            repeat (4) @(posedge aclk);
            count_out <= 1'b0;
            repeat (3) @(posedge aclk);
        end
        repeat (6) @(posedge aclk);
    endtask : pulse
endmodule : ctm_pin_model

// file: tb_ctm_timer.sv
// Testbench for the compact timer: registers, counting, output and PWM.
// Assumes the timer, pin model and bound checker are compiled first.
`timescale 1ns/100ps
module tb_ctm_timer;
    logic aclk, aresetn, high_clock_tick, timebase_clock_tick, external_count_input;
    logic timer_output_pin, timer_output_pin_oe, compare_a_flag, compare_p_flag;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, tick_cnt;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int mismatches = 0;
    int cmp_count = 0;

    ctm_timer u_ctm_timer (
        .aclk, .aresetn, .high_clock_tick, .timebase_clock_tick, .external_count_input,
        .timer_output_pin, .timer_output_pin_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .compare_a_flag, .compare_p_flag
    );
    ctm_pin_model u_ctm_pin_model (.aclk(aclk), .count_out(external_count_input));

    // ************************************************************
    // Clock and internal clock ticks
    // ************************************************************
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) begin
        tick_cnt <= tick_cnt + 4'h1;
        high_clock_tick <= tick_cnt[0];
        timebase_clock_tick <= tick_cnt == 4'hF;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_io(input logic [3:0] exp, input logic [3:0] mask);
        repeat (3) @(negedge aclk);
        chk({28'h0, mask & {compare_p_flag, compare_a_flag, timer_output_pin_oe, timer_output_pin}}, {28'h0, exp});
    endtask : chk_io

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic ta, tw, tb = 1'b0;
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!tb && n < 50) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid === 1'b1;
            if (tb) begin
                chk({30'h0, s_axi_bresp}, {30'h0, ctm_pkg::CTM_AXI_OKAY});
            end
            @(posedge aclk);
            s_axi_awvalid <= s_axi_awvalid && !ta;
            s_axi_wvalid <= s_axi_wvalid && !tw;
            s_axi_bready <= !tb;
            n++;
        end
        chk({31'h0, tb}, 32'h1);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [7:0] exp, input logic [1:0] resp = ctm_pkg::CTM_AXI_OKAY);
        logic ta, tr = 1'b0;
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!tr && n < 50) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid === 1'b1;
            if (tr) begin
                chk(s_axi_rdata, {24'h0, exp});
                chk({30'h0, s_axi_rresp}, {30'h0, resp});
            end
            @(posedge aclk);
            s_axi_arvalid <= s_axi_arvalid && !ta;
            s_axi_rready <= !tr;
            n++;
        end
        chk({31'h0, tr}, 32'h1);
    endtask : rd

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset_vals;
        for (int i = 0; i < 7; i++) begin
            rd(5'(i * 4), 8'h00);
        end
        rd(5'h1C, 8'h00, ctm_pkg::CTM_AXI_DECERR);
    endtask : t_reset_vals

    task automatic t_regs_and_count;
        wr(ctm_pkg::CTM_OFS_COMPARE_LOW, 8'h5A);
        wr(ctm_pkg::CTM_OFS_COMPARE_HIGH, 8'hFF);
        wr(ctm_pkg::CTM_OFS_COUNT_LOW, 8'h77);
        s_axi_wstrb <= 4'h0;
        wr(ctm_pkg::CTM_OFS_COMPARE_LOW, 8'h11);
        s_axi_wstrb <= 4'hF;
        rd(ctm_pkg::CTM_OFS_COMPARE_LOW, 8'h5A);
        rd(ctm_pkg::CTM_OFS_COMPARE_HIGH, 8'h03);
        rd(ctm_pkg::CTM_OFS_COUNT_LOW, 8'h00);
        wr(ctm_pkg::CTM_OFS_CONTROL_A, 8'h68);
        u_ctm_pin_model.pulse(5);
        rd(ctm_pkg::CTM_OFS_COUNT_LOW, 8'h05);
        wr(ctm_pkg::CTM_OFS_CONTROL_A, 8'hE8);
        u_ctm_pin_model.pulse(3);
        rd(ctm_pkg::CTM_OFS_COUNT_LOW, 8'h05);
        wr(ctm_pkg::CTM_OFS_CONTROL_A, 8'h78);
        u_ctm_pin_model.pulse(2);
        rd(ctm_pkg::CTM_OFS_COUNT_LOW, 8'h07);
        wr(ctm_pkg::CTM_OFS_CONTROL_A, 8'h70);
        u_ctm_pin_model.pulse(2);
        rd(ctm_pkg::CTM_OFS_COUNT_LOW, 8'h07);
        wr(ctm_pkg::CTM_OFS_CONTROL_A, 8'h78);
        rd(ctm_pkg::CTM_OFS_COUNT_LOW, 8'h00);
    endtask : t_regs_and_count

    task automatic t_out_func;
        wr(ctm_pkg::CTM_OFS_COMPARE_HIGH, 8'h00);
        wr(ctm_pkg::CTM_OFS_COMPARE_LOW, 8'h03);
        for (int f = 0; f < 4; f++) begin
            wr(ctm_pkg::CTM_OFS_CONTROL_A, 8'h60);
            wr(ctm_pkg::CTM_OFS_CONTROL_B, {2'h0, 2'(f), 4'h1});
            wr(ctm_pkg::CTM_OFS_CONTROL_A, 8'h68);
            chk_io(4'b0010, 4'h3);
            u_ctm_pin_model.pulse(4);
            chk_io({3'b001, 1'(f >= 2)}, 4'h3);
            rd(ctm_pkg::CTM_OFS_COUNT_LOW, 8'h00);
        end
        chk_io(4'b0100, 4'hC);
    endtask : t_out_func

    task automatic t_period_flags;
        for (int m = 0; m < 4; m += 3) begin
            wr(ctm_pkg::CTM_OFS_CONTROL_A, 8'h01);
            wr(ctm_pkg::CTM_OFS_FLAGS, 8'h03);
            wr(ctm_pkg::CTM_OFS_CONTROL_B, {2'(m), 6'h00});
            wr(ctm_pkg::CTM_OFS_CONTROL_A, 8'h09);
            repeat (480) @(posedge aclk);
            chk_io({2'b01, m == 0, 1'b0}, 4'hE);
            repeat (60) @(posedge aclk);
            chk_io({2'b11, m == 0, 1'b0}, 4'hE);
            rd(ctm_pkg::CTM_OFS_FLAGS, 8'h03);
        end
    endtask : t_period_flags

    task automatic t_pwm;
        wr(ctm_pkg::CTM_OFS_CONTROL_A, 8'h61);
        wr(ctm_pkg::CTM_OFS_COMPARE_LOW, 8'h40);
        wr(ctm_pkg::CTM_OFS_CONTROL_B, 8'hA9);
        wr(ctm_pkg::CTM_OFS_CONTROL_A, 8'h69);
        chk_io(4'b0011, 4'h3);
        u_ctm_pin_model.pulse(64);
        chk_io(4'b0010, 4'h3);
        wr(ctm_pkg::CTM_OFS_CONTROL_A, 8'h61);
        wr(ctm_pkg::CTM_OFS_CONTROL_B, 8'h9C);
        chk_io(4'b0000, 4'h1);
        wr(ctm_pkg::CTM_OFS_CONTROL_B, 8'h8C);
        chk_io(4'b0001, 4'h1);
        wr(ctm_pkg::CTM_OFS_COMPARE_HIGH, 8'h03);
        wr(ctm_pkg::CTM_OFS_COMPARE_LOW, 8'hFF);
        wr(ctm_pkg::CTM_OFS_CONTROL_B, 8'hA8);
        wr(ctm_pkg::CTM_OFS_CONTROL_A, 8'h69);
        u_ctm_pin_model.pulse(130);
        chk_io(4'b0011, 4'h3);
        wr(ctm_pkg::CTM_OFS_CONTROL_A, 8'h61);
        wr(ctm_pkg::CTM_OFS_CONTROL_B, 8'hAA);
        wr(ctm_pkg::CTM_OFS_CONTROL_A, 8'h69);
        u_ctm_pin_model.pulse(128);
        chk_io(4'b0010, 4'h3);
    endtask : t_pwm

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        tick_cnt = 4'h0;
        {high_clock_tick, timebase_clock_tick, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_vals();
        t_regs_and_count();
        t_out_func();
        t_period_flags();
        t_pwm();
        tally_and_finish();
    end

    // Several times the expected run
    initial begin
        #200us;
        mismatches++;
        tally_and_finish();
    end
endmodule : tb_ctm_timer
